// file: synth_defines.svh
`ifndef SYNTH_DEFINES_SVH
`define SYNTH_DEFINES_SVH
// Purpose: word layouts, field positions and counts of the synthesizer link
// Assumes: 24-bit serial words, control bits in [1:0]
// Notes: host register offsets are byte addresses on APB
`define WORD_W 24
`define ADDR_INT 2'h0
`define ADDR_DIVREF 2'h1
`define ADDR_CTRL 2'h2
`define ADDR_NOISE 2'h3
`define DR_MODULUS_LSB 2
`define DR_MODULUS_MSB 13
`define DR_RDIV_LSB 14
`define DR_RDIV_MSB 17
`define DR_PRESC_BIT 18
`define DR_LOADCTL_BIT 23
`define INT_NUMER_LSB 2
`define INT_NUMER_MSB 13
`define INT_INT_LSB 14
`define INT_INT_MSB 22
`define CT_CNTRST_BIT 2
`define CT_CPTRI_BIT 3
`define CT_PDN_BIT 4
`define CT_LOCK_PREC_BIT 5
`define CT_POL_BIT 6
`define CT_CP_LSB 7
`define CT_CP_MSB 10
`define CT_DBL_BIT 11
`define NS_MODE_LSB 2
`define NS_MODE_MSB 11
`define NS_LOW_SPUR 10'h000
`define NS_LOW_NOISE_SPUR 10'h3C0
`define NS_LOWEST_NOISE 10'h0F1
`define LOCK_CNT_FINE 6'h18
`define LOCK_CNT_COARSE 6'h28
`define SHIFT_HALF 4'h2
`define OFS_DATA 12'h000
`define OFS_CMD 12'h004
`define OFS_STATUS 12'h008
`define OFS_DIV 12'h00C
`define DIV_RESET 8'h02
`endif

// file: synth_pkg.sv
// Purpose: shared types of the synthesizer link
// Assumes: nothing
// Notes: modes as decoded by the device
package synth_pkg;
    typedef enum logic [1:0] {MODE_LOW_SPUR, MODE_LOW_NOISE_SPUR, MODE_LOWEST_NOISE} ns_mode_e;
    typedef enum logic [1:0] {H_IDLE, H_LOW, H_HIGH, H_LATCH} host_state_e;
endpackage

// file: synth_link_if.sv
// Purpose: 3-wire serial programming link
// Assumes: one clock, host makes the serial clock by division
// Notes: device samples all three pins through two flip-flops
interface synth_link_if;
    logic ser_clk;
    logic ser_data;
    logic ser_latch;
    modport host (output ser_clk, output ser_data, output ser_latch);
    modport device (input ser_clk, input ser_data, input ser_latch);
endinterface

// file: fraction_numerator_synth_control_regs.sv
// What this block does
// - host picks 8/9 prescaler above 2 GHz
// - host keeps division above 31 or 91
// - reference divided by 4-bit counter 1..15
// - modulus applies only after integer word write
// - control bits 1,0 route to control word
// - control bits 1,1 route to noise word
// - counter reset bit holds dividers in reset
// - tri-state bit floats charge pump
// - power-down bit; registers kept throughout
// - power-down loads counters, floats pump, clears lock
// - lock after 24 or 40 good cycles
// - lock held until new channel, power-down or 30 ns error
// - polarity bit selects phase detector sense
// - pump current from bits 7 to 10
// - doubler makes both reference edges active
// - host keeps doubler off above 30 MHz
// - noise mode sets dither and pump region
// - host writes zero to reserved bits
// - host follows the power-up write order
// - resync uses extra divider word, load bit one
// - load bit one sets resync delay, not modulus
// - 0,0 routes integer word, 0,1 divider word
// Purpose: register bank and control logic of the fractional-N device
// Assumes: reference input and lock comparison results are sampled on core_clk
// Notes: phase error arrives as two flags from the analog comparator
//
// The register addresses and the APB register port were decided locally.
module fraction_numerator_synth_control_regs
    import synth_pkg::*;
#(
    parameter int LOCK_W = 6
) (
    input wire logic core_clk,
    input wire logic srst,
    synth_link_if.device link,
    input wire logic reference_input,
    input wire logic err_under_15ns,
    input wire logic err_over_30ns,
    output logic phase_comparator_clk,
    output logic counters_reset,
    output logic cp_tristate,
    output logic powered_down,
    output logic detector_positive,
    output logic [3:0] cp_current,
    output logic dither_en,
    output logic cp_low_noise_region,
    output logic prescaler_89,
    output logic [8:0] int_value,
    output logic [11:0] fraction_numerator,
    output logic [11:0] fraction_modulus,
    output logic [11:0] resync_delay,
    output logic digital_lock
);
    `include "synth_defines.svh"

    logic [2:0] clk_s1_ff, clk_s2_ff;
    logic clk_prev_ff;
    logic [`WORD_W-1:0] shift_ff;
    logic [`WORD_W-1:0] int_word_ff, divref_word_ff, ctrl_word_ff, noise_word_ff;
    logic [11:0] modulus_pending_ff, modulus_active_ff, resync_ff;
    logic new_channel_ff;
    logic [1:0] ref_s_ff;
    logic ref_prev_ff;
    logic [3:0] rcnt_ff;
    logic cmp_clk_ff;
    logic [LOCK_W-1:0] lock_cnt_ff;
    logic lock_ff;
    logic sclk_rise, latch_rise, ref_edge, cmp_tick;
    logic [LOCK_W-1:0] lock_target;
    ns_mode_e mode;

    // pins from the host are asynchronous to core_clk
    always_ff @(posedge core_clk) begin
        if (srst) begin
            clk_s1_ff <= 3'h0;
            clk_s2_ff <= 3'h0;
        end else begin
            clk_s1_ff <= {link.ser_latch, link.ser_data, link.ser_clk};
            clk_s2_ff <= clk_s1_ff;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            clk_prev_ff <= 1'b0;
        end else begin
            clk_prev_ff <= clk_s2_ff[0];
        end
    end
    logic latch_prev_ff;
    always_ff @(posedge core_clk) begin
        if (srst) begin
            latch_prev_ff <= 1'b0;
        end else begin
            latch_prev_ff <= clk_s2_ff[2];
        end
    end
    assign sclk_rise = clk_s2_ff[0] && !clk_prev_ff;
    assign latch_rise = clk_s2_ff[2] && !latch_prev_ff;

    // shifting continues during power-down
    always_ff @(posedge core_clk) begin
        if (srst) begin
            shift_ff <= '0;
        end else if (sclk_rise) begin
            shift_ff <= {shift_ff[`WORD_W-2:0], clk_s2_ff[1]};
        end
    end

    // words persist through power-down; only srst clears them
    always_ff @(posedge core_clk) begin
        if (srst) begin
            int_word_ff <= '0;
            divref_word_ff <= '0;
            ctrl_word_ff <= '0;
            noise_word_ff <= '0;
        end else if (latch_rise) begin
            unique case (shift_ff[1:0])
                `ADDR_INT: int_word_ff <= shift_ff;
                `ADDR_DIVREF: divref_word_ff <= shift_ff;
                `ADDR_CTRL: ctrl_word_ff <= shift_ff;
                `ADDR_NOISE: noise_word_ff <= shift_ff;
            endcase
        end
    end

    // modulus is double buffered: pending on divider word, active on integer word
    always_ff @(posedge core_clk) begin
        if (srst) begin
            modulus_pending_ff <= '0;
            modulus_active_ff <= '0;
            resync_ff <= '0;
        end else if (latch_rise) begin
            if (shift_ff[1:0] == `ADDR_DIVREF) begin
                if (shift_ff[`DR_LOADCTL_BIT]) begin
                    resync_ff <= shift_ff[`DR_MODULUS_MSB:`DR_MODULUS_LSB];
                end else begin
                    modulus_pending_ff <= shift_ff[`DR_MODULUS_MSB:`DR_MODULUS_LSB];
                end
            end else if (shift_ff[1:0] == `ADDR_INT) begin
                modulus_active_ff <= modulus_pending_ff;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            new_channel_ff <= 1'b0;
        end else begin
            new_channel_ff <= latch_rise && (shift_ff[1:0] == `ADDR_INT);
        end
    end

    assign counters_reset = ctrl_word_ff[`CT_CNTRST_BIT] || ctrl_word_ff[`CT_PDN_BIT];
    assign cp_tristate = ctrl_word_ff[`CT_CPTRI_BIT] || ctrl_word_ff[`CT_PDN_BIT];
    assign powered_down = ctrl_word_ff[`CT_PDN_BIT];
    assign detector_positive = ctrl_word_ff[`CT_POL_BIT];
    assign cp_current = ctrl_word_ff[`CT_CP_MSB:`CT_CP_LSB];
    assign prescaler_89 = divref_word_ff[`DR_PRESC_BIT];
    assign int_value = int_word_ff[`INT_INT_MSB:`INT_INT_LSB];
    assign fraction_numerator = int_word_ff[`INT_NUMER_MSB:`INT_NUMER_LSB];
    assign fraction_modulus = modulus_active_ff;
    assign resync_delay = resync_ff;

    // unknown codes fall back to low spur
    always_comb begin
        unique case (noise_word_ff[`NS_MODE_MSB:`NS_MODE_LSB])
            `NS_LOW_NOISE_SPUR: mode = MODE_LOW_NOISE_SPUR;
            `NS_LOWEST_NOISE: mode = MODE_LOWEST_NOISE;
            default: mode = MODE_LOW_SPUR;
        endcase
    end
    assign dither_en = (mode == MODE_LOW_SPUR);
    assign cp_low_noise_region = (mode == MODE_LOWEST_NOISE);

    // reference sampled on core_clk; far slower than core_clk in this model
    always_ff @(posedge core_clk) begin
        if (srst) begin
            ref_s_ff <= 2'h0;
            ref_prev_ff <= 1'b0;
        end else begin
            ref_s_ff <= {ref_s_ff[0], reference_input};
            ref_prev_ff <= ref_s_ff[1];
        end
    end
    assign ref_edge = ctrl_word_ff[`CT_DBL_BIT] ? (ref_s_ff[1] != ref_prev_ff)
                                              : (!ref_s_ff[1] && ref_prev_ff);

    // ratio 0 is treated as 1
    always_ff @(posedge core_clk) begin
        if (srst || counters_reset) begin
            rcnt_ff <= 4'h0;
            cmp_clk_ff <= 1'b0;
        end else if (ref_edge) begin
            if (rcnt_ff + 4'h1 >= divref_word_ff[`DR_RDIV_MSB:`DR_RDIV_LSB]) begin
                rcnt_ff <= 4'h0;
                cmp_clk_ff <= 1'b1;
            end else begin
                rcnt_ff <= rcnt_ff + 4'h1;
                cmp_clk_ff <= 1'b0;
            end
        end else begin
            cmp_clk_ff <= 1'b0;
        end
    end
    assign cmp_tick = cmp_clk_ff;
    assign phase_comparator_clk = cmp_clk_ff;

    assign lock_target = ctrl_word_ff[`CT_LOCK_PREC_BIT] ? LOCK_W'(`LOCK_CNT_COARSE)
                                                   : LOCK_W'(`LOCK_CNT_FINE);
    always_ff @(posedge core_clk) begin
        if (srst || powered_down || new_channel_ff) begin
            lock_cnt_ff <= '0;
            lock_ff <= 1'b0;
        end else if (cmp_tick) begin
            if (err_over_30ns) begin
                lock_cnt_ff <= '0;
                lock_ff <= 1'b0;
            end else if (!err_under_15ns) begin
                lock_cnt_ff <= '0;
            end else if (!lock_ff) begin
                if (lock_cnt_ff + 1'b1 >= lock_target) begin
                    lock_ff <= 1'b1;
                end
                lock_cnt_ff <= lock_cnt_ff + 1'b1;
            end
        end
    end
    assign digital_lock = lock_ff;
endmodule

// file: synth_host.sv
// Purpose: host end; software sends 24-bit words over APB to the serial link
// Assumes: APB slave, zero wait states
// Notes: software owns prescaler, division limits, reserved bits and write order
module synth_host
    import synth_pkg::*;
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    synth_link_if.host link
);
    `include "synth_defines.svh"

    logic [`WORD_W-1:0] data_ff, shift_ff;
    logic [7:0] div_ff, tick_cnt_ff;
    logic [4:0] bits_ff;
    logic busy_ff;
    host_state_e state_ff;
    logic sclk_ff, sdata_ff, slatch_ff;
    logic wr, go, tick;

    assign pready = 1'b1;
    assign wr = psel && penable && pwrite;
    // word content and order are left to software
    assign go = wr && (paddr == `OFS_CMD) && pwdata[0] && !busy_ff;
    assign pslverr = psel && penable && !(paddr == `OFS_DATA || paddr == `OFS_CMD
        || paddr == `OFS_STATUS || paddr == `OFS_DIV);

    always_ff @(posedge core_clk) begin
        if (srst) begin
            data_ff <= '0;
            div_ff <= `DIV_RESET;
        end else if (wr && paddr == `OFS_DATA) begin
            data_ff <= pwdata[`WORD_W-1:0];
        end else if (wr && paddr == `OFS_DIV) begin
            div_ff <= (pwdata[7:0] == 8'h00) ? 8'h01 : pwdata[7:0];
        end
    end

    always_comb begin
        unique case (paddr)
            `OFS_DATA: prdata = {8'h00, data_ff};
            `OFS_STATUS: prdata = {31'h0, busy_ff};
            `OFS_DIV: prdata = {24'h0, div_ff};
            default: prdata = 32'h0;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (srst || state_ff == H_IDLE) begin
            tick_cnt_ff <= 8'h00;
        end else if (tick_cnt_ff + 8'h01 >= div_ff) begin
            tick_cnt_ff <= 8'h00;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 8'h01;
        end
    end
    assign tick = (state_ff != H_IDLE) && (tick_cnt_ff + 8'h01 >= div_ff);

    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_ff <= H_IDLE;
            busy_ff <= 1'b0;
            shift_ff <= '0;
            bits_ff <= 5'h00;
            sclk_ff <= 1'b0;
            sdata_ff <= 1'b0;
            slatch_ff <= 1'b0;
        end else begin
            unique case (state_ff)
                H_IDLE: begin
                    if (go) begin
                        busy_ff <= 1'b1;
                        shift_ff <= data_ff;
                        bits_ff <= 5'h00;
                        sdata_ff <= data_ff[`WORD_W-1];
                        state_ff <= H_LOW;
                    end
                end
                H_LOW: begin
                    if (tick) begin
                        sclk_ff <= 1'b1;
                        state_ff <= H_HIGH;
                    end
                end
                H_HIGH: begin
                    if (tick) begin
                        sclk_ff <= 1'b0;
                        if (bits_ff == 5'(`WORD_W - 1)) begin
                            state_ff <= H_LATCH;
                            slatch_ff <= 1'b1;
                        end else begin
                            bits_ff <= bits_ff + 5'h01;
                            shift_ff <= {shift_ff[`WORD_W-2:0], 1'b0};
                            sdata_ff <= shift_ff[`WORD_W-2];
                            state_ff <= H_LOW;
                        end
                    end
                end
                H_LATCH: begin
                    if (tick) begin
                        slatch_ff <= 1'b0;
                        busy_ff <= 1'b0;
                        state_ff <= H_IDLE;
                    end
                end
            endcase
        end
    end

    assign link.ser_clk = sclk_ff;
    assign link.ser_data = sdata_ff;
    assign link.ser_latch = slatch_ff;
endmodule

// file: synth_sva.sv
// Purpose: protocol and output checks on the joined serial link
// Assumes: host divider left at its reset value
// Notes: settings may only move shortly after a latch strobe
module synth_sva (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic ser_clk,
    input wire logic ser_data,
    input wire logic ser_latch,
    input wire logic phase_comparator_clk,
    input wire logic counters_reset,
    input wire logic cp_tristate,
    input wire logic powered_down,
    input wire logic detector_positive,
    input wire logic [3:0] cp_current,
    input wire logic dither_en,
    input wire logic cp_low_noise_region,
    input wire logic [11:0] fraction_modulus,
    input wire logic digital_lock,
    input wire logic err_over_30ns
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] since_latch_ff;
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    // saturates so a long idle never wraps back into the window
    always_ff @(posedge core_clk) begin
        if (srst) begin
            since_latch_ff <= 4'hF;
        end else if (ser_latch) begin
            since_latch_ff <= 4'h0;
        end else if (since_latch_ff != 4'hF) begin
            since_latch_ff <= since_latch_ff + 4'h1;
        end
    end
    property p_latch_len;
        $rose(ser_latch) |=> ser_latch ##1 !ser_latch;
    endproperty
    a_latch_len: assert property (p_latch_len) else $error("latch strobe length");
    property p_latch_noclk;
        ser_latch |-> !ser_clk;
    endproperty
    a_latch_noclk: assert property (p_latch_noclk) else $error("clock during latch");
    property p_data_hold;
        ser_clk |-> $stable(ser_data);
    endproperty
    a_data_hold: assert property (p_data_hold) else $error("data moved, clock high");
    property p_pd_effects;
        powered_down |-> counters_reset && cp_tristate;
    endproperty
    a_pd_effects: assert property (p_pd_effects) else $error("power-down effects");
    property p_pd_lock;
        powered_down |=> !digital_lock;
    endproperty
    a_pd_lock: assert property (p_pd_lock) else $error("lock while down");
    property p_lock_drop;
        phase_comparator_clk && err_over_30ns |-> ##[1:2] !digital_lock;
    endproperty
    a_lock_drop: assert property (p_lock_drop) else $error("lock kept on error");
    property p_modulus_latch;
        $changed(fraction_modulus) |-> since_latch_ff < 4'h8;
    endproperty
    a_modulus_latch: assert property (p_modulus_latch) else $error("modulus moved alone");
    property p_ctrl_latch;
        $changed({cp_current, detector_positive, powered_down}) |-> since_latch_ff < 4'h8;
    endproperty
    a_ctrl_latch: assert property (p_ctrl_latch) else $error("control moved alone");
    property p_mode_excl;
        !(dither_en && cp_low_noise_region);
    endproperty
    a_mode_excl: assert property (p_mode_excl) else $error("two noise modes");
    property p_rst_tick;
        counters_reset && $past(counters_reset) && $past(counters_reset, 2)
            |-> !phase_comparator_clk;
    endproperty
    a_rst_tick: assert property (p_rst_tick) else $error("tick in reset");
endmodule

// file: testbench.sv
// Purpose: host and device joined by the link, driven over APB
// Assumes: host divider stays 2
// Notes: reference toggles every 10 cycles, one falling edge per 20
`include "synth_defines.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 1'h0;
    logic srst = 1'h1;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, q;
    logic pready, pslverr, e;
    logic reference_input = 1'h0;
    logic err_under_15ns = 1'h0;
    logic err_over_30ns = 1'h0;
    logic phase_comparator_clk, counters_reset, cp_tristate, powered_down, detector_positive;
    logic dither_en, cp_low_noise_region, prescaler_89, digital_lock;
    logic [3:0] cp_current;
    logic [8:0] int_value;
    logic [11:0] fraction_numerator, fraction_modulus, resync_delay;
    logic [4:0] ref_div = 5'h0;
    int mismatches = 0;
    int checked = 0;
    int cycles = 0;
    int n;
    logic [23:0] ns_words [3] = '{24'h000003, 24'h0003C7, 24'h000F03};
    logic [1:0] ns_exp [3] = '{2'h2, 2'h1, 2'h0};
    synth_link_if link();
    synth_host u_synth_host (.core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(link));
    fraction_numerator_synth_control_regs u_fraction_numerator_synth_control_regs (.core_clk(core_clk), .srst(srst),
        .link(link), .reference_input(reference_input), .err_under_15ns(err_under_15ns),
        .err_over_30ns(err_over_30ns), .phase_comparator_clk(phase_comparator_clk),
        .counters_reset(counters_reset), .cp_tristate(cp_tristate),
        .powered_down(powered_down), .detector_positive(detector_positive),
        .cp_current(cp_current), .dither_en(dither_en),
        .cp_low_noise_region(cp_low_noise_region), .prescaler_89(prescaler_89),
        .int_value(int_value), .fraction_numerator(fraction_numerator),
        .fraction_modulus(fraction_modulus), .resync_delay(resync_delay),
        .digital_lock(digital_lock));
    synth_sva u_synth_sva (.core_clk(core_clk), .srst(srst), .ser_clk(link.ser_clk),
        .ser_data(link.ser_data), .ser_latch(link.ser_latch),
        .phase_comparator_clk(phase_comparator_clk), .counters_reset(counters_reset),
        .cp_tristate(cp_tristate), .powered_down(powered_down),
        .detector_positive(detector_positive), .cp_current(cp_current), .dither_en(dither_en),
        .cp_low_noise_region(cp_low_noise_region), .fraction_modulus(fraction_modulus),
        .digital_lock(digital_lock), .err_over_30ns(err_over_30ns));
    always #50 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        ref_div <= (ref_div == 5'h9) ? 5'h0 : ref_div + 5'h1;
        reference_input <= reference_input ^ (ref_div == 5'h9);
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            mismatches++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // waits an edge first so back-to-back calls never drive psel twice in one step
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'h1;
        @(posedge core_clk);
        while (pready !== 1'h1) @(posedge core_clk);
        q = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic send(input logic [23:0] w);
        apb(1'h1, `OFS_DATA, {8'h00, w});
        apb(1'h1, `OFS_CMD, 32'h1);
        q = 32'h1;
        while (q[0] !== 1'h0) apb(1'h0, `OFS_STATUS, 32'h0);
        repeat (8) @(posedge core_clk);
    endtask
    task automatic tick(input int k);
        repeat (k) begin
            @(posedge core_clk);
            while (phase_comparator_clk !== 1'h1) @(posedge core_clk);
        end
    endtask
    task automatic period(input logic [31:0] exp);
        tick(1);
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (phase_comparator_clk !== 1'h1);
        check("tick interval", n, exp);
    endtask
    initial begin
        repeat (8) @(posedge core_clk);
        srst <= 1'h0;
        apb(1'h0, `OFS_DIV, 32'h0);
        check("divider", q, 32'h2);
        apb(1'h0, 12'h010, 32'h0);
        check("unmapped error", {31'h0, e}, 32'h1);
        check("reset state", {int_value, digital_lock}, 32'h0);
        foreach (ns_words[i]) begin
            send(ns_words[i]);
            check("noise mode", {dither_en, cp_low_noise_region}, ns_exp[i]);
        end
        send(24'h000546);
        check("control", {counters_reset, cp_tristate, powered_down, detector_positive,
            cp_current}, 32'h9A);
        send(24'h00054E);
        check("tristate", cp_tristate, 32'h1);
        send(24'h044105);
        check("divider word", {prescaler_89, fraction_modulus}, 32'h1000);
        send(24'h84401D);
        check("resync", {resync_delay, fraction_modulus}, 32'h7000);
        send(24'h044105);
        send(24'h228078);
        check("integer word", {int_value, fraction_numerator}, 32'h8A01E);
        check("modulus", fraction_modulus, 32'h041);
        send(24'h000542);
        check("counters run", counters_reset, 32'h0);
        period(32'd20);
        send(24'h000D42);
        period(32'd10);
        send(24'h04C105);
        period(32'd30);
        for (int i = 0; i < 2; i++) begin
            send(i ? 24'h000D62 : 24'h000D42);
            err_under_15ns <= 1'h0;
            tick(2);
            err_under_15ns <= 1'h1;
            tick(i ? 39 : 23);
            repeat (3) @(posedge core_clk);
            check("lock early", digital_lock, 32'h0);
            tick(1);
            repeat (3) @(posedge core_clk);
            check("lock", digital_lock, 32'h1);
            err_over_30ns <= 1'h1;
            tick(1);
            err_over_30ns <= 1'h0;
            repeat (3) @(posedge core_clk);
            check("lock lost", digital_lock, 32'h0);
        end
        send(24'h000D52);
        check("power-down", {counters_reset, cp_tristate, powered_down}, 32'h7);
        send(24'h22807C);
        check("latched while down", fraction_numerator, 32'h01F);
        send(24'h000D42);
        check("resume", {powered_down, cp_current, fraction_modulus}, 32'hA041);
        give_verdict();
    end
endmodule
